// *** src/acs_sequencer.v ***
// serial converter control: frame engine, sequencer, coding, apb view
`timescale 1ns/100ps
`include "acs_map.vh"
module acs_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        din,
  output reg         dout,
  output reg         dout_oe,
  input  wire [12:0] sample_level,
  input  wire        sample_valid,
  output wire        sample_ready,
  output reg  [2:0]  mux_channel
);
  // frame states and sequencer modes, one-hot
  localparam ST_IDLE   = 2'b01;
  localparam ST_SHIFT  = 2'b10;
  localparam MD_NONE   = 3'b001;
  localparam MD_MASK   = 3'b010;
  localparam MD_CONS   = 3'b100;

  // ==========================================================
  // pin synchronisers
  reg  [2:0]  pin_s1;
  reg  [2:0]  pin_s2;
  reg  [2:0]  pin_d;
  wire        cs_fall  = ~pin_s2[2] & pin_d[2];
  wire        cs_rise  =  pin_s2[2] & ~pin_d[2];
  wire        sck_fall = ~pin_s2[1] & pin_d[1];
  wire        din_s    =  pin_s2[0];

  // s1 feeds only s2; edges come from s2 against its delayed copy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 3'b110;
      pin_s2 <= 3'b110;
      pin_d  <= 3'b110;
    end else begin
      pin_s1 <= {cs_n, sclk, din};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  // ==========================================================
  // state
  reg  [1:0]  state;
  reg  [4:0]  bit_cnt;
  reg  [15:0] tx_shift;
  reg  [15:0] rx_shift;
  reg  [11:0] ctrl;
  reg  [15:0] mask;
  reg  [2:0]  mode;
  reg         mask_arm;
  reg  [3:0]  slot;
  reg  [2:0]  ch_next;
  reg  [12:0] level_hold;
  reg  [15:0] last_word;
  reg  [15:0] frame_word;
  reg         frame_done;
  reg  [15:0] rx_word;

  wire [2:0]  ctrl_addr = ctrl[`ACS_ADDR_HI:`ACS_ADDR_LO];
  wire        start     = cs_fall & state[0];
  wire        buf_valid;
  wire [12:0] buf_data;
  wire [12:0] level_now = buf_valid ? buf_data : level_hold;
  // whole word kept aside, the shifter loses it bit by bit
  wire [15:0] word_now  = {1'b0, ch_next,
                           quantize(level_now, ctrl[`ACS_B_RANGE],
                                    ctrl[`ACS_B_CODING])};

  // sample levels queue up until a frame takes one
  acs_pair_buffer u_buf (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_data   (sample_level),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (start)
  );

  // ==========================================================
  // code shaping
  function [11:0] quantize;
    input [12:0] lv;
    input        rng;
    input        twos;
    reg   [11:0] c;
    begin
      // one code step per ref/4096 unit, clip above full scale
      if (rng)
        c = (lv > `ACS_LVL_TOP) ? `ACS_CODE_MAX : lv[11:0];
      else
        c = lv[12:1];                 // double span, step 2 units
      // flipping the top bit puts mid-scale at zero
      quantize = twos ? {~c[11], c[10:0]} : c;
    end
  endfunction

  // next selected mask slot after p, wrapping; slot s uses mask bit 15-s
  function [3:0] next_slot;
    input [15:0] m;
    input [3:0]  p;
    integer      i;
    reg   [3:0]  s;
    reg          hit;
    begin
      next_slot = p;
      hit       = 1'b0;
      for (i = 1; i <= 16; i = i + 1) begin
        s = p + i[3:0];
        if (!hit && m[`ACS_SLOT_TOP - s]) begin
          next_slot = s;
          hit       = 1'b1;
        end
      end
    end
  endfunction

  // ==========================================================
  // frame engine: sample at select fall, shift on each clock fall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_IDLE;
      bit_cnt     <= 5'd0;
      tx_shift    <= 16'h0000;
      rx_shift    <= 16'h0000;
      dout        <= 1'b0;
      dout_oe     <= 1'b0;
      frame_done  <= 1'b0;
      rx_word     <= 16'h0000;
      mux_channel <= 3'd0;
      level_hold  <= 13'h0000;
      last_word   <= 16'h0000;
      frame_word  <= 16'h0000;
    end else begin
      frame_done <= 1'b0;
      if (cs_rise)
        dout_oe <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            tx_shift    <= word_now;
            frame_word  <= word_now;
            dout        <= 1'b0;
            dout_oe     <= 1'b1;
            mux_channel <= ch_next;
            level_hold  <= level_now;
            bit_cnt     <= 5'd0;
            state       <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // early select rise drops the frame with no register update
          if (cs_rise) begin
            state <= ST_IDLE;
          end else if (sck_fall) begin
            rx_shift <= {rx_shift[14:0], din_s};
            tx_shift <= {tx_shift[14:0], 1'b0};
            dout     <= tx_shift[14];
            bit_cnt  <= bit_cnt + 5'd1;
            if (bit_cnt == `ACS_LAST_BIT) begin
              frame_done <= 1'b1;
              rx_word    <= {rx_shift[14:0], din_s};
              last_word  <= frame_word;
              state      <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // apb decode
  wire apb_acc   = psel & penable & pready;
  wire ctrl_wr   = apb_acc & pwrite & (paddr == `ACS_OFF_CTRL);

  // ==========================================================
  // sequencer next state
  reg  [11:0] next_ctrl;
  reg  [15:0] next_mask;
  reg  [2:0]  next_mode;
  reg         next_arm;
  reg  [3:0]  next_slot_r;
  reg  [2:0]  next_ch;
  reg         upd;
  reg         adv;
  reg  [11:0] wdata;
  reg  [3:0]  first;

  always @* begin
    next_ctrl   = ctrl;
    next_mask   = mask;
    next_mode   = mode;
    next_arm    = mask_arm;
    next_slot_r = slot;
    next_ch     = ch_next;
    upd         = 1'b0;
    adv         = frame_done;
    wdata       = ctrl;
    first       = next_slot(rx_word, `ACS_SLOT_TOP);
    if (frame_done && mask_arm) begin
      // whole frame is mask data, MSB first
      next_mask = rx_word;
      next_arm  = 1'b0;
      adv       = 1'b0;
      if (rx_word != `ACS_MASK_RST) begin
        next_mode   = MD_MASK;
        next_slot_r = first;
        next_ch     = first[2:0];
      end else begin
        next_mode = MD_NONE;
        next_ch   = ctrl_addr;
      end
    end else begin
      if (frame_done && rx_word[15]) begin
        upd   = 1'b1;
        wdata = rx_word[15:`ACS_CTRL_LO];
      end else if (ctrl_wr) begin
        upd   = 1'b1;
        wdata = pwdata[11:0];
      end
      if (upd) begin
        next_ctrl = wdata;
        case ({wdata[`ACS_B_SEQ], wdata[`ACS_B_SHADOW]})
          2'b10: begin
            // running sequence carries on untouched
            if (mode[0])
              next_ch = wdata[`ACS_ADDR_HI:`ACS_ADDR_LO];
          end
          2'b11: begin
            next_mode = MD_CONS;
            next_ch   = 3'd0;
            adv       = 1'b0;
          end
          2'b01: begin
            next_mode = MD_NONE;
            next_arm  = 1'b1;
            next_ch   = wdata[`ACS_ADDR_HI:`ACS_ADDR_LO];
            adv       = 1'b0;
          end
          default: begin
            next_mode = MD_NONE;
            next_ch   = wdata[`ACS_ADDR_HI:`ACS_ADDR_LO];
            adv       = 1'b0;
          end
        endcase
      end
      if (adv) begin
        case (mode)
          MD_MASK: begin
            next_slot_r = next_slot(mask, slot);
            next_ch     = next_slot_r[2:0];
          end
          MD_CONS: begin
            // final channel reached, restart at zero
            if (mux_channel >= next_ctrl[`ACS_ADDR_HI:`ACS_ADDR_LO])
              next_ch = 3'd0;
            else
              next_ch = mux_channel + 3'd1;
          end
          default: next_ch = next_ctrl[`ACS_ADDR_HI:`ACS_ADDR_LO];
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `ACS_CTRL_RST;
      mask     <= `ACS_MASK_RST;
      mode     <= MD_NONE;
      mask_arm <= 1'b0;
      slot     <= 4'h0;
      ch_next  <= 3'd0;
    end else begin
      ctrl     <= next_ctrl;
      mask     <= next_mask;
      mode     <= next_mode;
      mask_arm <= next_arm;
      slot     <= next_slot_r;
      ch_next  <= next_ch;
    end
  end

  // ==========================================================
  // apb slave: data and error fixed in setup, one access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `ACS_OFF_CTRL:   prdata <= {20'h00000, ctrl};
          `ACS_OFF_MASK:   begin
            prdata  <= {16'h0000, mask};
            pslverr <= pwrite;
          end
          `ACS_OFF_STATUS: begin
            prdata  <= {22'h000000, ~state[0], mask_arm, mode[2:1],
                        mux_channel, ch_next};
            pslverr <= pwrite;
          end
          `ACS_OFF_RESULT: begin
            prdata  <= {16'h0000, last_word};
            pslverr <= pwrite;
          end
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

// *** src/acs_map.vh ***
// constants for the eight-channel converter sequencer block
//
// Functional notes
// - coding bit (control LSB) picks straight binary or twos complement.
// - input split into 4096 equal steps: reference/4096 at range bit 1, 2*ref/4096 at range bit 0.
// - double range plus twos complement: reference gives code zero.
// - range bit 1 spans 0..ref, range bit 0 spans 0..2*ref.
// - each frame outputs zero, three channel bits, twelve result bits.
// - outside a sequence, the address bits pick the converted input.
// - after mask load, convert lowest selected, then next higher each transfer.
// - after the last selected channel, wrap to the first and repeat.
// - write with sequence/mask-select 1,0 leaves a running sequence alone.
// - any other sequence/mask-select pair in a write ends the sequence.
// - sequence/mask-select 1,1 runs channels 0 up to the address bits.
// - consecutive run restarts at 0 after the final channel.
// - 16-bit mask, MSB first, loads only in frame after a 0,1 write.
// - with write bit 1, first 12 data bits load the control register.
// - conversion starts at select fall and takes sixteen serial clocks.
// - with 0,0 each transfer picks next channel, sequencer idle.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// control word layout
`define ACS_CTRL_RST    12'h000
`define ACS_B_WRITE     11
`define ACS_B_SEQ       10
`define ACS_ADDR_HI     8
`define ACS_ADDR_LO     6
`define ACS_B_SHADOW    3
`define ACS_B_RANGE     1
`define ACS_B_CODING    0
`define ACS_CTRL_LO     4
`define ACS_MASK_RST    16'h0000

// frame and conversion figures
`define ACS_LAST_BIT    5'd15
`define ACS_LVL_TOP     13'h0FFF
`define ACS_CODE_MAX    12'hFFF
`define ACS_SLOT_TOP    4'hF
`define ACS_BUF_DEPTH   2'd2

// apb map
`define ACS_OFF_CTRL    8'h00
`define ACS_OFF_MASK    8'h04
`define ACS_OFF_STATUS  8'h08
`define ACS_OFF_RESULT  8'h0C

`endif

// *** src/acs_pair_buffer.v ***
// two-entry valid/ready buffer for incoming analog sample levels
`timescale 1ns/100ps
`include "acs_map.vh"
module acs_pair_buffer (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [12:0] in_data,
  input  wire        in_valid,
  output reg         in_ready,
  output wire [12:0] out_data,
  output wire        out_valid,
  input  wire        out_ready
);
  reg [12:0] mem [0:1];
  reg        wr_ptr;
  reg        rd_ptr;
  reg [1:0]  count;
  reg [1:0]  next_count;
  wire       push = in_valid & in_ready;
  wire       pop  = out_valid & out_ready;

  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rd_ptr];

  // ==========================================================
  // occupancy
  always @* begin
    next_count = count;
    if (push && !pop)
      next_count = count + 2'd1;
    else if (pop && !push)
      next_count = count - 2'd1;
  end

  // ready is registered so the top sees a flop, not a gate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count    <= 2'd0;
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      count    <= next_count;
      in_ready <= (next_count != `ACS_BUF_DEPTH);
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
    end
  end

  // storage carries no reset; only count qualifies it
  always @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
endmodule

// *** testbench/acs_seq_chk_props.sv ***
// assertions on the converter sequencer ports
`timescale 1ns/100ps
module acs_seq_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        cs_n,
  input wire        dout,
  input wire        dout_oe
);
  // ==============================
  // properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // setup phase of an apb transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // select idle long enough to pass the pin synchroniser
  sequence s_idle;
    cs_n [*6];
  endsequence
  property p_zero_wait;
    s_setup |=> pready;
  endproperty
  property p_one_cycle;
    pready |=> !pready;
  endproperty
  property p_err_valid;
    pslverr |-> pready;
  endproperty
  property p_unmapped;
    s_setup ##0 (paddr > 8'h0C) |=> pslverr;
  endproperty
  property p_ro_write;
    s_setup ##0 (pwrite && paddr != 8'h00) |=> pslverr;
  endproperty
  property p_err_zero;
    pslverr && !pwrite |-> prdata == 32'h0000_0000;
  endproperty
  property p_oe_on;
    $fell(cs_n) |-> ##[2:6] dout_oe;
  endproperty
  property p_lead_zero;
    $rose(dout_oe) |-> !dout;
  endproperty
  property p_oe_off;
    s_idle |-> !dout_oe;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access waited");
  a_one_cycle: assert property (p_one_cycle) else $error("ready too long");
  a_err_valid: assert property (p_err_valid) else $error("stray error");
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  a_ro_write: assert property (p_ro_write) else $error("ro write accepted");
  a_err_zero: assert property (p_err_zero) else $error("error data not 0");
  a_oe_on: assert property (p_oe_on) else $error("no drive");
  a_lead_zero: assert property (p_lead_zero) else $error("lead 1");
  a_oe_off: assert property (p_oe_off) else $error("drives idle");
endmodule
bind acs_sequencer acs_seq_chk i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .cs_n, .dout, .dout_oe
);

// *** testbench/acs_host_model.sv ***
// serial master model that runs one converter frame per go pulse
`timescale 1ns/100ps
module acs_host_model (
  input  wire        go,
  input  wire [15:0] tx,
  input  wire [4:0]  nclk,
  input  wire        dout,
  output reg         cs_n = 1'b1,
  output reg         sclk = 1'b1,
  output reg         din  = 1'b0,
  output reg         busy = 1'b0,
  output reg         done = 1'b0,
  output reg  [15:0] rx   = 16'h0000
);
  integer k;
  // ==============================
  // frame engine; link clock stands high outside frames
  always @(posedge go) begin
    busy = 1'b1;
    #7 cs_n = 1'b0;
    #80;
    for (k = 0; k < nclk; k = k + 1) begin
      rx[15-k] = dout;
      din = tx[15-k];
      #40 sclk = 1'b0;
      #80 sclk = 1'b1;
      #40;
    end
    cs_n = 1'b1;  // all sixteen falls unless aborting
    din = ~din;   // released line must not keep a stale bit
    #200 done = nclk == 5'd16;
    #20 done = 1'b0;
    busy = 1'b0;
  end
endmodule

// *** testbench/test_acs_sequencer.sv ***
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module test_acs_sequencer;
  // ==============================
  // mode table: word sent, channel expected
  localparam logic [15:0] WD [0:16] = '{16'hC8A0, 16'h0, 16'h0, 16'h0,
    16'h0, 16'hC820, 16'h0, 16'h0, 16'h9420, 16'h0, 16'h94A0, 16'h2480,
    16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  localparam logic [2:0] CH [0:16] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h0,
    3'h1, 3'h2, 3'h0, 3'h1, 3'h5, 3'h5, 3'h5, 3'h2, 3'h5, 3'h0, 3'h2,
    3'h5};
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        cs_n;
  wire        sclk;
  wire        din;
  wire        dout;
  wire        dout_oe;
  reg  [12:0] sample_level;
  reg         sample_valid;
  wire        sample_ready;
  wire [2:0]  mux_channel;
  reg         go;
  reg  [15:0] tx;
  reg  [4:0]  nclk;
  wire        busy;
  wire        done;
  wire [15:0] rx;
  integer     failures;
  integer     check_count;
  integer     i;
  reg  [31:0] seed;
  reg  [11:0] ctrl;
  reg  [15:0] last;
  reg  [15:0] exp_q[$];
  reg  [12:0] lv_q[$];
  acs_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cs_n, .sclk, .din, .dout,
    .dout_oe, .sample_level, .sample_valid, .sample_ready, .mux_channel);
  acs_host_model i_host (.go, .tx, .nclk, .dout, .cs_n, .sclk, .din,
    .busy, .done, .rx);
  // ==============================
  // helpers
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  function [15:0] word(input [12:0] lv, input [11:0] c, input [2:0] k);
    reg [11:0] code;
    begin
      code = c[1] ? (lv > 13'h0FFF ? 12'hFFF : lv[11:0]) : lv[12:1];
      code[11] = code[11] ^ c[0];
      word = {1'b0, k, code};
    end
  endfunction
  task check(input [31:0] seen, input [31:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        failures = failures + 1;
        $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task hang;
    begin
      failures = failures + 1;
      $display("[ERR] %0t wait ran out", $time);
      test_done;
    end
  endtask
  // apb transfer; request held until pready is seen at an edge
  task apb(input w, input [7:0] a, input [31:0] d, input [31:0] want,
           input e);
    integer n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 20) hang;
      check({31'h0, pslverr}, {31'h0, e});
      if (!w) check(prdata, want);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task push(input [12:0] lv);
    integer t;
    begin
      t = 0;
      @(posedge pclk);
      while (sample_ready !== 1'b1 && t < 100) begin
        t = t + 1;
        @(posedge pclk);
      end
      if (t == 100) hang;
      sample_level <= lv;
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
      lv_q.push_back(lv);
    end
  endtask
  // one frame; the note is queued before the link moves
  task frame(input [15:0] w, input [4:0] n, input [2:0] k);
    integer t;
    reg [12:0] lv;
    begin
      lv = lv_q.pop_front();
      last = word(lv, ctrl, k);
      if (n == 5'd16) exp_q.push_back(last);
      tx <= w;
      nclk <= n;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      t = 0;
      @(posedge pclk);
      while (busy !== 1'b0 && t < 400) begin
        t = t + 1;
        @(posedge pclk);
      end
      if (t == 400) hang;
      check({29'h0, mux_channel}, {29'h0, k});
      if (n == 5'd16 && w[15]) ctrl = w[15:4];
      seed = xs(seed);
      push(seed[12:0]);
    end
  endtask
  // ==============================
  // clock, result monitor, main sequence
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge done) begin
    check({16'h0, rx}, exp_q.size() != 0 ? {16'h0, exp_q.pop_front()}
                                         : 32'hFFFF_FFFF);
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_level = 13'h0;
    sample_valid = 1'b0;
    go = 1'b0;
    tx = 16'h0;
    nclk = 5'd16;
    failures = 0;
    check_count = 0;
    seed = 32'd71534;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h04, 32'hFFFF, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'hFFFF_F002, 32'h0, 1'b0);
    apb(1'b0, 8'h00, 32'h0, 32'h0000_0002, 1'b0);
    ctrl = 12'h002;
    push(13'h0FFF);
    push(13'h1000);
    @(posedge pclk);
    check({31'h0, sample_ready}, 32'h0);
    // every range and coding pair, channel picked by the address
    for (i = 0; i < 4; i = i + 1)
      frame({3'b100, i[2:0] + 3'd4, 4'h0, i[1:0] ^ 2'd1, 4'h0},
            5'd16, i == 0 ? 3'h0 : i[2:0] + 3'd3);
    frame(16'h0, 5'd16, 3'h7);
    // consecutive run, mid-run write, end, mask load and wrap
    for (i = 0; i < 17; i = i + 1)
      frame(WD[i], 5'd16, CH[i]);
    frame(16'h8000, 5'd8, 3'h0);
    frame(16'h0, 5'd16, 3'h0);
    frame(16'h0, 5'd16, 3'h2);
    apb(1'b0, 8'h0C, 32'h0, {16'h0, last}, 1'b0);
    test_done;
  end
endmodule
